// ===== src/low_power_mode_controller.sv
// Purpose: Sequences sleep, stop and standby and gates clocks, oscillators and regulator.
// Assumes: All inputs synchronous to clk_sys; por_n is the always-on power-on reset.
// Notes: Outputs are registered; every stop and standby wake source is ignored on battery supply, but periph_irq still ends sleep.
// Summary of operation
// - Sleep halts only the processor clock; any peripheral interrupt or event wakes it.
// - Stop gates all core clocks and disables PLL and both oscillators; state kept.
// - During stop the regulator is normal or low-power as configured.
// - Any external event line source wakes the device from stop.
// - Standby turns off regulator, PLL, oscillators; only backup state survives, but the code also keeps detector_level_select through standby wake.
// - Standby exits on reset pin, watchdog reset, wakeup pin rise, or RTC event.
// - RTC, independent watchdog and their clocks keep running in stop and standby.
// - Twenty retained 32-bit backup words survive system reset and standby wake.
// - On battery supply, external interrupts and RTC events do not end battery operation.
// - Three-bit detector level select picks threshold, codes increasing from 000.
// - Codes 100 through 111 are also valid and continue the sequence.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defines.svh"
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int EXT_LINES = `LPM_EXT_LINES,
  parameter int SETTLE_CYC = `LPM_OSC_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic [1:0] mode_req,
  input wire logic enter_strobe,
  input wire logic regulator_low_power_cfg,
  input wire logic [`LPM_LEVEL_SEL_W-1:0] detector_level_select_in,
  input wire logic level_select_wr,
  input wire logic periph_irq,
  input wire logic [EXT_LINES-1:0] external_event_lines,
  input wire logic programmable_voltage_detector_out,
  input wire logic rtc_event,
  input wire logic usb_wakeup,
  input wire logic eth_wakeup,
  input wire logic wakeup_pin,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog_reset,
  input wire logic on_battery,
  input wire logic bkp_wr_en,
  input wire logic [`LPM_BACKUP_IDX_W-1:0] bkp_wr_idx,
  input wire logic [31:0] bkp_wr_data,
  input wire logic [`LPM_BACKUP_IDX_W-1:0] bkp_rd_idx,
  output logic [31:0] bkp_rd_data,
  output logic cpu_clk_en,
  output logic core_clk_en,
  output logic pll_en,
  output logic internal_rc_oscillator_en,
  output logic external_crystal_oscillator_en,
  output logic regulator_on,
  output logic regulator_low_power,
  output logic core_reset_n,
  output logic always_on_clk_en,
  output logic [`LPM_LEVEL_SEL_W-1:0] detector_level_select,
  output logic [1:0] mode_status
);
  lpm_state_e state_reg, state_next;
  logic [`LPM_CNT_W-1:0] cnt_reg, cnt_next;
  logic wkp_d_reg;
  logic [`LPM_LEVEL_SEL_W-1:0] lvl_reg, lvl_next;
  logic cpu_clk_next, core_clk_next, osc_next, reg_on_next, reg_lp_next, rst_n_next;
  logic [1:0] status_next;
  logic stop_wake, standby_wake, wkp_rise;

  backup_regs #(.WORDS(`LPM_BACKUP_WORDS)) u_backup (
    .clk_sys(clk_sys),
    .por_n(por_n),
    .wr_en(bkp_wr_en && !on_battery),
    .wr_idx(bkp_wr_idx),
    .wr_data(bkp_wr_data),
    .rd_idx(bkp_rd_idx),
    .rd_data(bkp_rd_data)
  );

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      wkp_d_reg <= 1'b0;
    else
      wkp_d_reg <= wakeup_pin;
  end
  assign wkp_rise = wakeup_pin && !wkp_d_reg;

  // Battery operation blocks every stop and standby wake source; periph_irq still ends sleep on battery.
  assign stop_wake = !on_battery && ((|external_event_lines) || programmable_voltage_detector_out
    || rtc_event || usb_wakeup || eth_wakeup);
  assign standby_wake = !on_battery && (!external_reset_pin_n || independent_watchdog_reset
    || wkp_rise || rtc_event);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    if (level_select_wr && state_reg == ST_RUN)
      lvl_next = detector_level_select_in;
    case (state_reg)
      ST_RUN:
      begin
        if (enter_strobe)
        begin
          case (mode_req)
            2'h1: state_next = ST_SLEEP;
            2'h2: state_next = ST_STOP;
            2'h3: state_next = ST_STANDBY;
            default: state_next = ST_RUN;
          endcase
        end
      end
      ST_SLEEP:
      begin
        if (periph_irq || stop_wake)
          state_next = ST_RUN;
      end
      ST_STOP:
      begin
        if (stop_wake)
        begin
          state_next = ST_WAKE_OSC;
          cnt_next = '0;
        end
      end
      ST_WAKE_OSC:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == `LPM_CNT_W'(SETTLE_CYC - 1))
          state_next = ST_RUN;
      end
      ST_STANDBY:
      begin
        if (standby_wake)
        begin
          state_next = ST_WAKE_RST;
          cnt_next = '0;
        end
      end
      ST_WAKE_RST:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == `LPM_CNT_W'(SETTLE_CYC + `LPM_RESET_HOLD_CYC - 1))
          state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end

  // Outputs follow the next state so that each is a flop without an extra cycle of lag.
  always_comb
  begin
    cpu_clk_next = (state_next == ST_RUN);
    core_clk_next = (state_next == ST_RUN) || (state_next == ST_SLEEP);
    osc_next = (state_next == ST_RUN) || (state_next == ST_SLEEP)
      || (state_next == ST_WAKE_OSC) || (state_next == ST_WAKE_RST);
    reg_on_next = (state_next != ST_STANDBY);
    reg_lp_next = (state_next == ST_STOP) && regulator_low_power_cfg;
    rst_n_next = (state_next != ST_STANDBY) && (state_next != ST_WAKE_RST);
    case (state_next)
      ST_SLEEP: status_next = 2'h1;
      ST_STOP, ST_WAKE_OSC: status_next = 2'h2;
      ST_STANDBY, ST_WAKE_RST: status_next = 2'h3;
      default: status_next = 2'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_RUN;
      cnt_reg <= '0;
      lvl_reg <= `LPM_LEVEL_SEL_RST;
      cpu_clk_en <= 1'b1;
      core_clk_en <= 1'b1;
      pll_en <= 1'b1;
      internal_rc_oscillator_en <= 1'b1;
      external_crystal_oscillator_en <= 1'b1;
      regulator_on <= 1'b1;
      regulator_low_power <= 1'b0;
      core_reset_n <= 1'b1;
      always_on_clk_en <= 1'b1;
      detector_level_select <= `LPM_LEVEL_SEL_RST;
      mode_status <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
      cpu_clk_en <= cpu_clk_next;
      core_clk_en <= core_clk_next;
      pll_en <= osc_next;
      internal_rc_oscillator_en <= osc_next;
      external_crystal_oscillator_en <= osc_next;
      regulator_on <= reg_on_next;
      regulator_low_power <= reg_lp_next;
      core_reset_n <= rst_n_next;
      always_on_clk_en <= 1'b1;
      detector_level_select <= lvl_next;
      mode_status <= status_next;
    end
  end

  a_sleep_cpu_only: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_SLEEP) |-> (!cpu_clk_en && core_clk_en))
    else $error("sleep must gate only the cpu clock");
  a_stop_clocks_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_STOP) |-> (!core_clk_en && !pll_en && !external_crystal_oscillator_en
    && regulator_on && core_reset_n))
    else $error("stop must gate clocks and oscillators");
  a_stop_regulator: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_STOP) |-> (regulator_low_power == $past(regulator_low_power_cfg)))
    else $error("stop regulator mode mismatch");
  a_stop_wakes: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_STOP && stop_wake) |=> (state_reg == ST_WAKE_OSC))
    else $error("stop wake ignored");
  a_standby_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_STANDBY) |-> (!regulator_on && !internal_rc_oscillator_en && !core_reset_n))
    else $error("standby must power down");
  a_standby_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_STANDBY && standby_wake) |=> (state_reg == ST_WAKE_RST) ##[1:40]
    (state_reg == ST_RUN))
    else $error("standby exit failed");
  a_always_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    always_on_clk_en)
    else $error("always-on clock gated");
  a_battery_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (on_battery && state_reg == ST_STANDBY) |=> (state_reg == ST_STANDBY))
    else $error("left standby on battery");
  a_osc_before_cpu: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(cpu_clk_en) |-> (pll_en && $past(pll_en)))
    else $error("cpu released before oscillators");
  c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_SLEEP) ##1 (state_reg == ST_RUN));
  c_stop_wake: cover property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_WAKE_OSC) ##1 (state_reg == ST_RUN));
  c_standby_wake: cover property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == ST_WAKE_RST) ##1 (state_reg == ST_RUN));
endmodule // low_power_mode_controller
`default_nettype wire

// ===== src/lpm_defines.svh
// Purpose: Constants for the low-power mode controller.
// Assumes: Included by its bare name.
// Notes: Timing counts are in cycles of the 25 MHz system clock.
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH
`define LPM_EXT_LINES 16
`define LPM_BACKUP_WORDS 20
`define LPM_BACKUP_IDX_W 5
`define LPM_LEVEL_SEL_W 3
`define LPM_LEVEL_SEL_RST 3'h0
`define LPM_OSC_SETTLE_NS 400
`define LPM_CLK_PERIOD_NS 40
`define LPM_OSC_SETTLE_CYC ((`LPM_OSC_SETTLE_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_CNT_W 8
`define LPM_RESET_HOLD_CYC 4
`endif

// ===== src/lpm_pkg.sv
// Purpose: Types for the low-power mode controller.
// Assumes: Nothing beyond the defines header.
// Notes: Mode request encoding is shared with the core side.
package lpm_pkg;
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_STOP, MODE_STANDBY} mode_req_e;
  typedef enum {ST_RUN, ST_SLEEP, ST_STOP, ST_STANDBY, ST_WAKE_OSC, ST_WAKE_RST} lpm_state_e;
endpackage

// ===== src/backup_regs.sv
// Purpose: Retained backup word store.
// Assumes: Lives on the always-on supply; only the power-on reset clears it.
// Notes: System reset and standby wake do not reach this module.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defines.svh"
module backup_regs #(
  parameter int WORDS = `LPM_BACKUP_WORDS
) (
  input wire logic clk_sys,
  input wire logic por_n,
  input wire logic wr_en,
  input wire logic [`LPM_BACKUP_IDX_W-1:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [`LPM_BACKUP_IDX_W-1:0] rd_idx,
  output logic [31:0] rd_data
);
  logic [31:0] mem_reg [WORDS];
  logic [31:0] mem_next [WORDS];
  genvar i;
  generate
    for (i = 0; i < WORDS; i++)
    begin : g_word
      always_comb
      begin
        mem_next[i] = mem_reg[i];
        if (wr_en && (32'(wr_idx) == i))
          mem_next[i] = wr_data;
      end
      always_ff @(posedge clk_sys or negedge por_n)
      begin
        if (!por_n)
          mem_reg[i] <= 32'h0000_0000;
        else
          mem_reg[i] <= mem_next[i];
      end
    end
  endgenerate
  always_ff @(posedge clk_sys or negedge por_n)
  begin
    if (!por_n)
      rd_data <= 32'h0000_0000;
    else
      rd_data <= (32'(rd_idx) < WORDS) ? mem_reg[rd_idx] : 32'h0000_0000;
  end
endmodule // backup_regs
`default_nettype wire

// ===== testbench/low_power_mode_controller_tb.sv
// Purpose: Self-checking bench for the low-power mode controller.
// Assumes: Inputs change on the falling clock edge; outputs are registered.
// Notes: The settle count is shortened so every wake wait stays brief.
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_tb;
  logic clk_sys, resetn, por_n, enter_strobe, regulator_low_power_cfg, level_select_wr;
  logic periph_irq, rtc_event, wakeup_pin, on_battery, bkp_wr_en, rst_seen;
  logic [1:0] mode_req, mode_status;
  logic [2:0] detector_level_select_in, detector_level_select;
  logic [15:0] external_event_lines;
  logic [4:0] bkp_wr_idx, bkp_rd_idx;
  logic [31:0] bkp_wr_data, bkp_rd_data;
  logic cpu_clk_en, core_clk_en, pll_en, internal_rc_oscillator_en;
  logic external_crystal_oscillator_en, regulator_on, regulator_low_power, core_reset_n;
  logic always_on_clk_en;
  logic external_reset_pin_n, independent_watchdog_reset, programmable_voltage_detector_out;
  int err_count = 0;
  int checks_done = 0;
  low_power_mode_controller #(.EXT_LINES(16), .SETTLE_CYC(3)) dut (
    .clk_sys, .resetn, .por_n, .mode_req, .enter_strobe, .regulator_low_power_cfg,
    .detector_level_select_in, .level_select_wr, .periph_irq, .external_event_lines,
    .programmable_voltage_detector_out, .rtc_event, .usb_wakeup(1'b0),
    .eth_wakeup(1'b0), .wakeup_pin, .external_reset_pin_n,
    .independent_watchdog_reset, .on_battery, .bkp_wr_en, .bkp_wr_idx,
    .bkp_wr_data, .bkp_rd_idx, .bkp_rd_data, .cpu_clk_en, .core_clk_en, .pll_en,
    .internal_rc_oscillator_en, .external_crystal_oscillator_en, .regulator_on,
    .regulator_low_power, .core_reset_n, .always_on_clk_en, .detector_level_select,
    .mode_status
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task finish_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task enter(input logic [1:0] m);
    mode_req = m;
    enter_strobe = 1'b1;
    step(1);
    enter_strobe = 1'b0;
  endtask
  // Bounded wait for run; the processor clock must never lead the core clocks.
  task wait_run(input string msg);
    int i;
    rst_seen = 1'b0;
    for (i = 0; i < 60 && !(mode_status === 2'h0 && cpu_clk_en === 1'b1); i++)
    begin
      step(1);
      // Reset must be held while the oscillators already run, not only during standby.
      if (core_reset_n === 1'b0 && pll_en === 1'b1)
        rst_seen = 1'b1;
      chk(cpu_clk_en !== 1'b1 || (pll_en === 1'b1 && core_clk_en === 1'b1), "cpu early");
    end
    if (i == 60)
    begin
      chk(1'b0, msg);
      finish_test();
    end
  endtask
  task test_sleep();
    enter(2'h1);
    chk(cpu_clk_en === 1'b0 && core_clk_en === 1'b1 && pll_en === 1'b1, "sleep gating");
    chk(mode_status === 2'h1, "sleep status");
    step(3);
    periph_irq = 1'b1;
    wait_run("sleep wake");
    periph_irq = 1'b0;
  endtask
  task test_stop();
    for (int k = 0; k < 3; k++)
    begin
      regulator_low_power_cfg = k[0];
      enter(2'h2);
      chk(core_clk_en === 1'b0 && cpu_clk_en === 1'b0 && pll_en === 1'b0, "stop clk");
      chk(internal_rc_oscillator_en === 1'b0 && external_crystal_oscillator_en === 1'b0,
          "stop osc");
      chk(regulator_on === 1'b1 && regulator_low_power === k[0], "stop reg");
      chk(always_on_clk_en === 1'b1, "always-on clock");
      periph_irq = 1'b1;
      step(3);
      chk(mode_status === 2'h2, "irq left stop");
      periph_irq = 1'b0;
      external_event_lines = (k < 2) ? (16'h0001 << (k * 15)) : 16'h0000;
      programmable_voltage_detector_out = (k == 2);
      wait_run("stop wake");
      external_event_lines = 16'h0000;
      programmable_voltage_detector_out = 1'b0;
    end
    regulator_low_power_cfg = 1'b0;
  endtask
  task test_standby();
    for (int k = 0; k < 4; k++)
    begin
      enter(2'h3);
      chk(regulator_on === 1'b0 && pll_en === 1'b0 && internal_rc_oscillator_en === 1'b0
          && external_crystal_oscillator_en === 1'b0, "standby power");
      chk(always_on_clk_en === 1'b1, "always-on clock");
      on_battery = 1'b1;
      rtc_event = 1'b1;
      step(4);
      chk(mode_status === 2'h3 && regulator_on === 1'b0, "battery wake");
      rtc_event = 1'b0;
      on_battery = 1'b0;
      step(1);
      wakeup_pin = (k == 0);
      rtc_event = (k == 1);
      external_reset_pin_n = (k != 2);
      independent_watchdog_reset = (k == 3);
      wait_run("standby wake");
      chk(rst_seen === 1'b1, "no core reset");
      wakeup_pin = 1'b0;
      rtc_event = 1'b0;
      external_reset_pin_n = 1'b1;
      independent_watchdog_reset = 1'b0;
    end
  endtask
  task test_level_backup();
    // The write strobe stays high across the codes so that it is never lowered and raised at once.
    level_select_wr = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      detector_level_select_in = c[2:0];
      step(1);
      chk(detector_level_select === c[2:0], "level code");
    end
    level_select_wr = 1'b0;
    bkp_wr_idx = 5'h13;
    bkp_wr_data = 32'hA5A5_5A5A;
    bkp_wr_en = 1'b1;
    step(1);
    bkp_wr_en = 1'b0;
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    bkp_rd_idx = 5'h13;
    step(1);
    chk(bkp_rd_data === 32'hA5A5_5A5A, "backup lost");
    chk(detector_level_select === 3'h0, "level reset");
    bkp_rd_idx = 5'h14;
    step(1);
    chk(bkp_rd_data === 32'h0000_0000, "beyond last word");
  endtask
  initial
  begin
    {resetn, por_n, enter_strobe, regulator_low_power_cfg, level_select_wr} = 5'h00;
    {periph_irq, rtc_event, wakeup_pin, on_battery, bkp_wr_en} = 5'h00;
    mode_req = 2'h0;
    {external_reset_pin_n, independent_watchdog_reset, programmable_voltage_detector_out} = 3'h4;
    detector_level_select_in = 3'h0;
    external_event_lines = 16'h0000;
    bkp_wr_idx = 5'h00;
    bkp_rd_idx = 5'h00;
    bkp_wr_data = 32'h0000_0000;
    rst_seen = 1'b0;
    step(16);
    resetn = 1'b1;
    por_n = 1'b1;
    step(1);
    chk(cpu_clk_en === 1'b1 && pll_en === 1'b1 && mode_status === 2'h0, "reset state");
    test_sleep();
    test_stop();
    test_standby();
    test_level_backup();
    finish_test();
  end
endmodule // low_power_mode_controller_tb
`default_nettype wire
